// *** core/cor_pkg.sv ***
package cor_pkg;

    localparam logic [9:0] COR_IDX_IND = 10'h000;
    localparam logic [9:0] COR_IDX_TICK = 10'h001;
    localparam logic [9:0] COR_IDX_PC = 10'h002;
    localparam logic [9:0] COR_IDX_STATUS = 10'h003;
    localparam logic [9:0] COR_IDX_RAMSEL = 10'h004;
    localparam logic [9:0] COR_IDX_CTRL = 10'h005;
    localparam logic [9:0] COR_IDX_STATE = 10'h006;
    localparam logic [5:0] COR_FIRST_DATA = 6'h05;

    localparam int unsigned COR_PC_W = 12;
    localparam logic [11:0] COR_PC_RESET = 12'hfff;
    localparam int unsigned COR_STACK_DEPTH = 5;
    localparam logic [2:0] COR_STACK_FULL = 3'h5;

    localparam logic [7:0] COR_STATUS_RESET = 8'h18;
    localparam logic [7:0] COR_TICK_RESET = 8'h00;
    localparam logic [7:0] COR_RAMSEL_RESET = 8'h00;
    localparam logic [7:0] COR_CTRL_RESET = 8'h00;
    localparam int unsigned COR_ST_SPARE = 7;
    localparam int unsigned COR_ST_PAGEHI = 6;
    localparam int unsigned COR_ST_PAGELO = 5;
    localparam int unsigned COR_ST_TOUT = 4;
    localparam int unsigned COR_ST_PDOWN = 3;
    localparam int unsigned COR_ST_ZERO = 2;
    localparam int unsigned COR_ST_HCARRY = 1;
    localparam int unsigned COR_ST_CARRY = 0;
    localparam int unsigned COR_CTRL_FOUR = 0;

    // Last divider count for fclk/2 and fclk/4 instruction cycles.
    localparam logic [1:0] COR_DIV2_LAST = 2'h1;
    localparam logic [1:0] COR_DIV4_LAST = 2'h3;

    typedef enum logic [3:0] {
        COR_OP_STEP,
        COR_OP_JUMP,
        COR_OP_CALL,
        COR_OP_RTN,
        COR_OP_RTNLIT,
        COR_OP_RTNINT,
        COR_OP_MOVPC,
        COR_OP_ADDPC,
        COR_OP_TABLE,
        COR_OP_WRPC,
        COR_OP_SLEEP,
        COR_OP_WDCLR,
        COR_OP_WDTOUT,
        COR_OP_FLAGS
    } cor_op_t;

    typedef struct packed {
        cor_op_t op;
        logic [9:0] target;
        logic [7:0] acc;
        logic [7:0] data;
        logic zero;
        logic half_carry;
        logic carry;
    } cor_instr_t;

endpackage : cor_pkg

// *** core/cor_regs.sv ***
// Local design decision: register access over APB.
`timescale 1ns/100ps
module cor_regs
    import cor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cor_instr_t instr,
    input wire logic instr_valid,
    output logic instr_done,
    output logic pc_busy,
    output logic [11:0] pc_addr,
    output logic [1:0] bank_sel
);

    logic [7:0] tick_q;
    logic [7:0] status_q;
    logic [7:0] ramsel_q;
    logic [7:0] ctrl_q;
    logic [COR_PC_W-1:0] pc_q;
    logic [COR_PC_W-1:0] pc_d;
    logic [COR_PC_W-1:0] stack_q [0:COR_STACK_DEPTH-1];
    logic [2:0] depth_q;
    logic [7:0] data_mem [0:255];
    logic [1:0] div_q;
    logic icyc_q;
    logic stall_q;
    logic done_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic [9:0] word;
    logic addr_ok;
    logic extra;
    logic [5:0] reg_sel;
    logic [31:0] rd_val;
    logic wr;
    logic take;
    logic push;
    logic pop;
    logic [1:0] page;
    logic [COR_PC_W-1:0] table_sum;
    logic [7:0] add_sum;

    // True for every operation that replaces the sequential address.
    function automatic logic cor_pc_jump(input cor_op_t op);
        case (op)
            COR_OP_JUMP, COR_OP_CALL, COR_OP_RTN, COR_OP_RTNLIT,
            COR_OP_RTNINT, COR_OP_MOVPC, COR_OP_ADDPC, COR_OP_TABLE,
            COR_OP_WRPC: cor_pc_jump = 1'b1;
            default: cor_pc_jump = 1'b0;
        endcase
    endfunction : cor_pc_jump

    function automatic logic cor_is_rtn(input cor_op_t op);
        cor_is_rtn = (op == COR_OP_RTN) || (op == COR_OP_RTNLIT)
            || (op == COR_OP_RTNINT);
    endfunction : cor_is_rtn

    // The high page bit does not exist on this variant.
    assign page = {1'b0, status_q[COR_ST_PAGELO]};

    always_comb
    begin
        word = paddr[11:2];
        addr_ok = (paddr[1:0] == 2'h0) && (word <= COR_IDX_STATE);
        extra = (word == COR_IDX_CTRL) || (word == COR_IDX_STATE);
        if (word == COR_IDX_IND)
        begin
            reg_sel = ramsel_q[5:0];
        end
        else
        begin
            reg_sel = word[5:0];
        end
    end

    always_comb
    begin
        rd_val = 32'h0;
        if (word == COR_IDX_CTRL)
        begin
            rd_val = {24'h0, ctrl_q};
        end
        else if (word == COR_IDX_STATE)
        begin
            rd_val = {28'h0, stall_q, depth_q};
        end
        else
        begin
            case (reg_sel)
                6'h00: rd_val = 32'h0;
                COR_IDX_TICK[5:0]: rd_val = {24'h0, tick_q};
                COR_IDX_PC[5:0]: rd_val = {20'h0, pc_q};
                COR_IDX_STATUS[5:0]: rd_val = {24'h0, status_q};
                COR_IDX_RAMSEL[5:0]: rd_val = {24'h0, ramsel_q};
                default: rd_val = {24'h0, data_mem[{ramsel_q[7:6], reg_sel}]};
            endcase
        end
    end

    // Zero wait states: pready rises for the access phase of every
    // transfer, so the write strobe is the access edge itself.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else if (psel && !penable)
        begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_ok;
            prdata_q <= (addr_ok && !pwrite) ? rd_val : 32'h0;
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign wr = psel && penable && pready_q && pwrite && addr_ok;
    assign take = instr_valid && icyc_q && !stall_q;
    assign push = take && (instr.op == COR_OP_CALL);
    assign pop = take && cor_is_rtn(instr.op);

    // Instruction cycle enable from the fast clock.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 2'h0;
            icyc_q <= 1'b0;
        end
        else
        begin
            if (div_q == (ctrl_q[COR_CTRL_FOUR] ? COR_DIV4_LAST
                : COR_DIV2_LAST))
            begin
                div_q <= 2'h0;
                icyc_q <= 1'b1;
            end
            else
            begin
                div_q <= div_q + 2'h1;
                icyc_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_q <= COR_TICK_RESET;
        end
        else if (wr && !extra && reg_sel == COR_IDX_TICK[5:0])
        begin
            tick_q <= pwdata[7:0];
        end
        else if (icyc_q)
        begin
            tick_q <= tick_q + 8'h01;
        end
    end

    always_comb
    begin
        table_sum = pc_q + {4'h0, instr.acc};
        add_sum = pc_q[7:0] + instr.acc;
        case (instr.op)
            COR_OP_JUMP: pc_d = {page, instr.target};
            COR_OP_CALL: pc_d = {page, instr.target};
            COR_OP_RTN, COR_OP_RTNLIT, COR_OP_RTNINT:
                pc_d = stack_q[0];
            COR_OP_MOVPC: pc_d = {page, 2'h0, instr.acc};
            COR_OP_ADDPC: pc_d = {page, 2'h0, add_sum};
            COR_OP_TABLE: pc_d = {page, table_sum[9:0]};
            COR_OP_WRPC: pc_d = {page, 2'h0, instr.data};
            default: pc_d = pc_q + 12'h001;
        endcase
    end

    // A decoder operation wins over a bus write in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_q <= COR_PC_RESET;
        end
        else if (take)
        begin
            pc_q <= pc_d;
        end
        else if (wr && !extra && reg_sel == COR_IDX_PC[5:0])
        begin
            pc_q <= {page, 2'h0, pwdata[7:0]};
        end
    end

    // Shift stack with the top at entry 0; a sixth call drops the
    // oldest return address, a return past empty repeats the last.
    // Neighbours are chosen at elaboration so no entry ever indexes
    // outside the stack.
    genvar gi;
    generate
        for (gi = 0; gi < COR_STACK_DEPTH; gi++)
        begin : g_stack
            logic [COR_PC_W-1:0] above;
            logic [COR_PC_W-1:0] below;
            if (gi == 0)
            begin : g_top
                assign above = pc_q + 12'h001;
            end
            else
            begin : g_inner
                assign above = stack_q[gi-1];
            end
            if (gi == COR_STACK_DEPTH - 1)
            begin : g_bottom
                assign below = stack_q[gi];
            end
            else
            begin : g_upper
                assign below = stack_q[gi+1];
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    stack_q[gi] <= COR_PC_RESET;
                end
                else if (push)
                begin
                    stack_q[gi] <= above;
                end
                else if (pop)
                begin
                    stack_q[gi] <= below;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            depth_q <= 3'h0;
        end
        else if (push && depth_q != COR_STACK_FULL)
        begin
            depth_q <= depth_q + 3'h1;
        end
        else if (pop && depth_q != 3'h0)
        begin
            depth_q <= depth_q - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stall_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= take;
            if (take)
            begin
                stall_q <= cor_pc_jump(instr.op);
            end
            else if (icyc_q)
            begin
                stall_q <= 1'b0;
            end
        end
    end

    // Hardware flag updates come last so they win over a bus write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q <= COR_STATUS_RESET;
        end
        else
        begin
            if (wr && !extra && reg_sel == COR_IDX_STATUS[5:0])
            begin
                status_q[COR_ST_SPARE] <= pwdata[COR_ST_SPARE];
                status_q[COR_ST_PAGELO] <= pwdata[COR_ST_PAGELO];
                status_q[COR_ST_ZERO] <= pwdata[COR_ST_ZERO];
                status_q[COR_ST_HCARRY] <= pwdata[COR_ST_HCARRY];
                status_q[COR_ST_CARRY] <= pwdata[COR_ST_CARRY];
            end
            status_q[COR_ST_PAGEHI] <= 1'b0;
            if (take)
            begin
                case (instr.op)
                    COR_OP_SLEEP:
                    begin
                        status_q[COR_ST_TOUT] <= 1'b1;
                        status_q[COR_ST_PDOWN] <= 1'b0;
                    end
                    COR_OP_WDCLR:
                    begin
                        status_q[COR_ST_TOUT] <= 1'b1;
                        status_q[COR_ST_PDOWN] <= 1'b1;
                    end
                    COR_OP_WDTOUT: status_q[COR_ST_TOUT] <= 1'b0;
                    COR_OP_FLAGS:
                    begin
                        status_q[COR_ST_ZERO] <= instr.zero;
                        status_q[COR_ST_HCARRY] <= instr.half_carry;
                        status_q[COR_ST_CARRY] <= instr.carry;
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramsel_q <= COR_RAMSEL_RESET;
        end
        else if (wr && !extra && reg_sel == COR_IDX_RAMSEL[5:0])
        begin
            ramsel_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= COR_CTRL_RESET;
        end
        else if (wr && word == COR_IDX_CTRL)
        begin
            ctrl_q <= {7'h0, pwdata[COR_CTRL_FOUR]};
        end
    end

    // Data registers behind the pointer; the bank bits extend the
    // address so each bank keeps its own copy.
    always_ff @(posedge pclk)
    begin
        if (wr && !extra && reg_sel >= COR_FIRST_DATA)
        begin
            data_mem[{ramsel_q[7:6], reg_sel}] <= pwdata[7:0];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign instr_done = done_q;
    assign pc_busy = stall_q;
    assign pc_addr = pc_q;
    assign bank_sel = ramsel_q[7:6];

endmodule : cor_regs

// *** testbench/cor_decoder_model.sv ***
`timescale 1ns/100ps
module cor_decoder_model
    import cor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_done,
    output cor_instr_t instr,
    output logic instr_valid
);
    initial
    begin
        instr = '0;
        instr_valid = 1'b0;
    end

    // A gap delays the request so the core also sees a late decoder.
    task automatic issue(input cor_op_t op, input logic [9:0] tgt,
        input logic [7:0] acc, input logic [7:0] dat, input logic [2:0] fl,
        input int gap, output logic ok);
        int n;
        repeat (gap + 1) @(posedge pclk);
        instr <= '{op, tgt, acc, dat, fl[2], fl[1], fl[0]};
        instr_valid <= presetn;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 40)
        begin
            @(posedge pclk);
            ok = (instr_done === 1'b1);
            n++;
        end
        // Scrambled once released, so stale fields can never pass a check.
        instr_valid <= 1'b0;
        instr <= cor_instr_t'(~instr);
    endtask : issue
endmodule : cor_decoder_model

// *** testbench/cor_regs_properties.sv ***
`timescale 1ns/100ps
module cor_regs_properties
    import cor_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire cor_instr_t instr,
    input wire logic instr_valid,
    input wire logic instr_done,
    input wire logic pc_busy,
    input wire logic [11:0] pc_addr,
    input wire logic [1:0] bank_sel
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_reset_pc: assert property (
        $rose(presetn) |-> pc_addr == 12'hfff) else $error("pc not reset");
    a_jump_target: assert property (
        instr_done && instr.op == COR_OP_JUMP |->
        pc_addr[9:0] == instr.target && !pc_addr[11]) else $error("jump");
    a_call_target: assert property (
        instr_done && instr.op == COR_OP_CALL |->
        pc_addr[9:0] == instr.target) else $error("call target");
    a_move_low: assert property (
        instr_done && instr.op == COR_OP_MOVPC |->
        pc_addr[9:0] == {2'h0, instr.acc}) else $error("move to pc");
    a_write_clear: assert property (
        instr_done && instr.op == COR_OP_WRPC |->
        pc_addr[9:0] == {2'h0, instr.data}) else $error("pc write");
    a_table_sum: assert property (
        instr_done && instr.op == COR_OP_TABLE |->
        pc_addr[9:0] == 10'($past(pc_addr) + 12'(instr.acc)))
        else $error("table jump");
    a_busy_span: assert property (
        $rose(pc_busy) |=> pc_busy ##[1:3] !pc_busy)
        else $error("busy length");
    a_busy_after_jump: assert property (
        instr_done && instr.op inside {COR_OP_JUMP, COR_OP_CALL, COR_OP_RTN,
        COR_OP_MOVPC, COR_OP_TABLE, COR_OP_WRPC} |-> pc_busy)
        else $error("no extra cycle");
    a_bank_hold: assert property (
        !(psel && penable && pwrite) |=> $stable(bank_sel))
        else $error("bank moved");

    c_jump: cover property (instr_done && instr.op == COR_OP_JUMP);
    c_table: cover property (instr_done && instr.op == COR_OP_TABLE);
    c_refused: cover property (pready && pslverr);
endmodule : cor_regs_properties

bind cor_regs cor_regs_properties cor_regs_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr(instr),
    .instr_valid(instr_valid), .instr_done(instr_done),
    .pc_busy(pc_busy), .pc_addr(pc_addr), .bank_sel(bank_sel)
);

// *** testbench/tb_core_operational_regs_pc.sv ***
`timescale 1ns/100ps
module tb_core_operational_regs_pc;
    import cor_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, instr_valid, instr_done, pc_busy, err;
    cor_instr_t instr;
    logic [11:0] pc_addr;
    logic [1:0] bank_sel;
    logic [7:0] t0;
    int fails = 0;
    int compares = 0;
    cor_op_t ops[8] = '{COR_OP_MOVPC, COR_OP_TABLE, COR_OP_ADDPC,
        COR_OP_WRPC, COR_OP_SLEEP, COR_OP_WDTOUT, COR_OP_WDCLR, COR_OP_FLAGS};
    logic [7:0] av[8] = '{8'hab, 8'h80, 8'h10, 8'h77, 8'h00, 8'h00, 8'h00,
        8'h05};
    logic [31:0] ex[8] = '{32'h4ab, 32'h52b, 32'h43b, 32'h477, 32'h030,
        32'h020, 32'h038, 32'h03d};

    always #2.5 pclk = ~pclk;

    cor_regs cor_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr(instr),
        .instr_valid(instr_valid), .instr_done(instr_done),
        .pc_busy(pc_busy), .pc_addr(pc_addr), .bank_sel(bank_sel)
    );

    cor_decoder_model cor_decoder_model_inst (
        .pclk(pclk), .presetn(presetn), .instr_done(instr_done),
        .instr(instr), .instr_valid(instr_valid)
    );

    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic pchk(input string what, input logic [31:0] exp);
        check(what, 32'(pc_addr), exp);
    endtask : pchk

    // One idle edge before setup keeps two transfers from colliding.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [7:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            test_done();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rchk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 8'h0, rd, err);
        check(what, rd, exp);
    endtask : rchk

    task automatic run(input cor_op_t o, input logic [9:0] t,
        input logic [7:0] a, input logic [2:0] f, input int gap);
        logic ok;
        cor_decoder_model_inst.issue(o, t, a, a, f, gap, ok);
        if (!ok)
        begin
            fails++;
            test_done();
        end
    endtask : run

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("status reset", 12'h00c, 32'h18);
        rchk("pc reset", 12'h008, 32'hfff);
        wr(12'h004, 8'h40);
        apb(1'b0, 12'h004, 8'h0, rd, err);
        check("tick write", rd & 32'hfe, 32'h40);
        for (int k = 0; k < 2; k++)
        begin
            wr(12'h014, 8'(k));
            for (int i = 0; i < 5; i++)
            begin
                apb(1'b0, 12'h004, 8'h0, rd, err);
                if (i == 0)
                    t0 = rd[7:0];
            end
            t0 = rd[7:0] - t0;
            check("tick rate", 32'(t0), k ? 32'h3 : 32'h6);
        end
        $display("test tick done");
        wr(12'h010, 8'he0);
        rchk("ram select", 12'h010, 32'he0);
        check("bank", 32'(bank_sel), 32'h3);
        wr(12'h000, 8'h5a);
        wr(12'h010, 8'h20);
        wr(12'h000, 8'ha5);
        wr(12'h010, 8'he0);
        rchk("banked data", 12'h000, 32'h5a);
        wr(12'h010, 8'h04);
        rchk("indirect self", 12'h000, 32'h04);
        wr(12'h00c, 8'hff);
        rchk("status write", 12'h00c, 32'hbf);
        apb(1'b0, 12'h01c, 8'h0, rd, err);
        check("unmapped", {rd[30:0], err}, 32'h1);
        $display("test registers done");
        wr(12'h00c, 8'h20);
        run(COR_OP_JUMP, 10'h3c5, 8'h0, 3'h0, 0);
        check("jump", 32'(pc_addr), 32'h7c5);
        run(COR_OP_CALL, 10'h010, 8'h0, 3'h0, 0);
        check("call", 32'(pc_addr), 32'h410);
        wr(12'h00c, 8'h00);
        run(COR_OP_RTN, 10'h0, 8'h0, 3'h0, 2);
        check("return", 32'(pc_addr), 32'h7c6);
        wr(12'h00c, 8'h20);
        for (int i = 0; i < 8; i++)
        begin
            run(ops[i], 10'h0, av[i], i == 7 ? av[i][2:0] : 3'h0, i % 3);
            if (i < 4)
                pchk("pc op", ex[i]);
            else
                rchk("status", 12'h00c, ex[i]);
        end
        $display("test program counter done");
        repeat (6) run(COR_OP_CALL, 10'h0, 8'h0, 3'h0, 0);
        apb(1'b0, 12'h018, 8'h0, rd, err);
        check("depth", rd & 32'h7, 32'h5);
        run(COR_OP_RTNLIT, 10'h0, 8'h0, 3'h0, 1);
        check("deep return", 32'(pc_addr), 32'h401);
        run(COR_OP_RTNINT, 10'h0, 8'h0, 3'h0, 0);
        pchk("second return", 32'h401);
        run(COR_OP_STEP, 10'h0, 8'h0, 3'h0, 0);
        pchk("step", 32'h402);
        $display("test stack done");
        test_done();
    end
endmodule : tb_core_operational_regs_pc
